/* File: lps_mode_ctrl.sv */
// Functional notes
// - start powered down, no conversion
// - results read zero until conversion
// - one-shot write starts single conversion
// - one-shot ends in power-down, keeps result
// - continuous mode reconverts, overwrites results
// - power-down write stops conversion
// - integration counted by oscillator, n-bit counter
// - results unsigned n-bit, n up to 16
// - integrating converter up to 16 bits
// - proximity mode drives the IR LED
// - LED current, frequency from command II
// - ranges one through four selectable
// - mode changes accepted back to back
// - three-bit mode field decode
// - results hold latest conversion
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lps_mode_ctrl (
  input  wire  logic        CLK_SYS,
  input  wire  logic        ARST_N,
  input  wire  logic [31:0] HADDR,
  input  wire  logic [1:0]  HTRANS,
  input  wire  logic        HWRITE,
  input  wire  logic [2:0]  HSIZE,
  input  wire  logic [31:0] HWDATA,
  input  wire  logic        HSEL,
  input  wire  logic        HREADY,
  input  wire  logic [15:0] LIGHT_IN,
  output var   logic [31:0] HRDATA,
  output var   logic        HREADYOUT,
  output var   logic        HRESP,
  output var   logic        LED_DRIVE_EN,
  output var   logic [1:0]  LED_CURRENT_SEL,
  output var   logic [1:0]  RANGE_SEL,
  output var   logic [1:0]  SENSE_CHANNEL,
  output var   logic        CONV_ACTIVE
);

  // decode helpers used by both the mode logic and the assertions
  function automatic logic [2:0] eff_mode(input logic [2:0] code);
    eff_mode = (code == lps_pkg::MODE_RESERVED) ? lps_pkg::MODE_PDOWN : code;
  endfunction

  function automatic logic is_cont(input logic [2:0] code);
    is_cont = code[2] && (code != lps_pkg::MODE_RESERVED);
  endfunction

  function automatic logic is_prox(input logic [2:0] code);
    is_prox = (code[1:0] == 2'h3);
  endfunction

  logic [7:0]               cmd1;
  lps_pkg::cmd2_s           cmd2;
  logic [15:0]              data;
  logic [15:0]              osc_div;
  logic [15:0]              osc_cnt;
  logic                     osc_tick;
  lps_pkg::conv_state_e     state;
  logic                     start;
  logic                     abort;
  logic                     busy;
  lps_pkg::result_s         result;
  logic                     mode_wr;
  logic [7:0]               mod_cnt;
  logic                     mod_phase;
  logic                     ap_valid;
  logic                     ap_write;
  logic [7:0]               ap_addr;
  logic                     dp_write;
  logic [7:0]               dp_addr;
  logic [2:0]               mode;

  assign mode = eff_mode(cmd1[lps_pkg::MODE_LSB +: lps_pkg::MODE_W]);

  // ---------------- AHB-Lite slave, zero wait states ----------------
  assign ap_valid = HSEL && HREADY && HTRANS[1];
  assign ap_write = HWRITE;
  assign ap_addr  = HADDR[7:0];

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      dp_write  <= ap_valid && ap_write;
      dp_addr   <= ap_addr;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // read data registered in the address phase so HRDATA is a flop output
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (ap_valid && !ap_write) begin
      unique case (ap_addr)
        lps_pkg::CMD1_ADDR:    HRDATA <= {24'h00_0000, cmd1};
        lps_pkg::CMD2_ADDR:    HRDATA <= {24'h00_0000, cmd2};
        lps_pkg::DATA_ADDR:    HRDATA <= {16'h0000, data};
        lps_pkg::STATUS_ADDR:  HRDATA <= {29'h0000_0000, busy, state == lps_pkg::ST_DONE, |mode};
        lps_pkg::OSC_DIV_ADDR: HRDATA <= {16'h0000, osc_div};
        default:               HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------- command registers ----------------
  assign mode_wr = dp_write && (dp_addr == lps_pkg::CMD1_ADDR);

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd1 <= lps_pkg::CMD1_RESET;
    end else if (mode_wr) begin
      cmd1 <= {HWDATA[7:5], 2'b00, 1'b0, HWDATA[1:0]};
    end else if (state == lps_pkg::ST_DONE && !is_cont(mode)) begin
      cmd1[lps_pkg::MODE_LSB +: lps_pkg::MODE_W] <= lps_pkg::MODE_PDOWN;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd2 <= lps_pkg::CMD2_RESET;
    end else if (dp_write && dp_addr == lps_pkg::CMD2_ADDR) begin
      cmd2 <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_div <= lps_pkg::OSC_DIV_RESET;
    end else if (dp_write && dp_addr == lps_pkg::OSC_DIV_ADDR) begin
      osc_div <= (HWDATA[15:0] == 16'h0000) ? 16'h0001 : HWDATA[15:0];
    end
  end

  // ---------------- internal oscillator stand-in ----------------
  // runs only while converting, so power-down really stops all activity
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_cnt  <= 16'h0000;
      osc_tick <= 1'b0;
    end else if (state != lps_pkg::ST_INTEG) begin
      osc_cnt  <= 16'h0000;
      osc_tick <= 1'b0;
    end else if (osc_cnt >= osc_div - 16'h0001) begin
      osc_cnt  <= 16'h0000;
      osc_tick <= 1'b1;
    end else begin
      osc_cnt  <= osc_cnt + 16'h0001;
      osc_tick <= 1'b0;
    end
  end

  // ---------------- sequencing ----------------
  // a mode write restarts the run; a power-down write aborts it
  assign start = (state == lps_pkg::ST_IDLE) && (mode != lps_pkg::MODE_PDOWN) && !mode_wr;
  assign abort = mode_wr;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= lps_pkg::ST_IDLE;
    end else if (mode_wr) begin
      state <= lps_pkg::ST_IDLE;
    end else begin
      unique case (state)
        lps_pkg::ST_IDLE:  if (start) state <= lps_pkg::ST_INTEG;
        lps_pkg::ST_INTEG: if (result.valid) state <= lps_pkg::ST_DONE;
        lps_pkg::ST_DONE:  state <= lps_pkg::ST_IDLE;
      endcase
    end
  end

  lps_integrator u_integrator (
    .clk      (CLK_SYS),
    .arst_n   (ARST_N),
    .start    (start),
    .abort    (abort),
    .osc_tick (osc_tick),
    .res      (cmd2.res),
    .light_in (LIGHT_IN),
    .busy     (busy),
    .result   (result)
  );

  // whole 16-bit word in one edge: no torn byte reads
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      data <= lps_pkg::DATA_RESET;
    end else if (result.valid && !mode_wr) begin
      data <= result.count;
    end
  end

  // ---------------- LED driver ----------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      mod_cnt   <= 8'h00;
      mod_phase <= 1'b0;
    end else if (state != lps_pkg::ST_INTEG) begin
      mod_cnt   <= 8'h00;
      mod_phase <= 1'b1;
    end else if (mod_cnt == lps_pkg::MOD_HALF_CYC - 8'h01) begin
      mod_cnt   <= 8'h00;
      mod_phase <= !mod_phase;
    end else begin
      mod_cnt   <= mod_cnt + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      LED_DRIVE_EN    <= 1'b0;
      LED_CURRENT_SEL <= 2'h0;
      RANGE_SEL       <= 2'h0;
      SENSE_CHANNEL   <= 2'h0;
      CONV_ACTIVE     <= 1'b0;
    end else begin
      // freq 0 is steady drive, freq 1 is square-wave modulation
      LED_DRIVE_EN    <= (state == lps_pkg::ST_INTEG) && is_prox(mode) && !mode_wr &&
                         (!cmd2.freq || mod_phase);
      LED_CURRENT_SEL <= cmd2.drive;
      RANGE_SEL       <= cmd2.range;
      SENSE_CHANNEL   <= mode[1:0];
      CONV_ACTIVE     <= (state == lps_pkg::ST_INTEG) && !mode_wr;
    end
  end

  // ---------------- assertions ----------------
  sequence s_oneshot_done;
    state == lps_pkg::ST_DONE && !is_cont(mode) && !mode_wr;
  endsequence

  a_oneshot_pdown: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_oneshot_done |=> mode == lps_pkg::MODE_PDOWN && state == lps_pkg::ST_IDLE ##1 state == lps_pkg::ST_IDLE)
    else $error("one-shot did not return to power-down");

  a_pdown_idle: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (mode == lps_pkg::MODE_PDOWN && !mode_wr) |=> !CONV_ACTIVE && !busy)
    else $error("conversion active in power-down");

  a_pdown_stop: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (mode_wr && HWDATA[7:5] == lps_pkg::MODE_PDOWN) |=> state == lps_pkg::ST_IDLE ##1 !busy)
    else $error("power-down write did not stop conversion");

  a_reserved_off: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (mode_wr && HWDATA[7:5] == lps_pkg::MODE_RESERVED) |=> ##1 !busy[*3])
    else $error("reserved mode started conversion");

  a_start_run: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (state == lps_pkg::ST_IDLE && mode != lps_pkg::MODE_PDOWN && !mode_wr) |=> busy)
    else $error("mode write did not start conversion");

  a_data_update: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (result.valid && !mode_wr) |=> data == $past(result.count))
    else $error("result not captured");

  a_data_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !result.valid |=> $stable(data))
    else $error("data changed without a result");

  a_led_prox: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    LED_DRIVE_EN |-> is_prox(mode) && $past(state) == lps_pkg::ST_INTEG)
    else $error("LED driven outside proximity run");

  // a host mode write in the idle cycle legally cancels the restart
  sequence s_cont_restart;
    (state == lps_pkg::ST_DONE && is_cont(mode) && !mode_wr) ##1 !mode_wr;
  endsequence

  a_cont_again: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_cont_restart |=> busy)
    else $error("continuous mode did not reconvert");

endmodule
`default_nettype wire

/* File: lps_pkg.sv */
`default_nettype none
package lps_pkg;

  // register byte addresses (one aligned word each)
  localparam logic [7:0] CMD1_ADDR        = 8'h00;
  localparam logic [7:0] CMD2_ADDR        = 8'h04;
  localparam logic [7:0] DATA_ADDR        = 8'h08;
  localparam logic [7:0] STATUS_ADDR      = 8'h0C;
  localparam logic [7:0] OSC_DIV_ADDR     = 8'h10;

  // command register I fields
  localparam int MODE_LSB   = 5;
  localparam int MODE_W     = 3;
  localparam int PRST_LSB   = 0;
  // command register II fields
  localparam int SCHEME_BIT = 7;
  localparam int FREQ_BIT   = 6;
  localparam int IS_LSB     = 4;
  localparam int RES_LSB    = 2;
  localparam int RANGE_LSB  = 0;

  localparam logic [7:0]  CMD1_RESET    = 8'h00;
  localparam logic [7:0]  CMD2_RESET    = 8'h00;
  localparam logic [15:0] DATA_RESET    = 16'h0000;
  localparam logic [15:0] OSC_DIV_RESET = 16'h0004;

  // mode codes
  localparam logic [2:0] MODE_PDOWN     = 3'h0;
  localparam logic [2:0] MODE_AMB_ONCE  = 3'h1;
  localparam logic [2:0] MODE_IR_ONCE   = 3'h2;
  localparam logic [2:0] MODE_PROX_ONCE = 3'h3;
  localparam logic [2:0] MODE_RESERVED  = 3'h4;
  localparam logic [2:0] MODE_AMB_CONT  = 3'h5;
  localparam logic [2:0] MODE_IR_CONT   = 3'h6;
  localparam logic [2:0] MODE_PROX_CONT = 3'h7;

  // resolution codes: 16, 12, 8, 4 bits
  localparam logic [1:0] RES_16 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;
  localparam logic [1:0] RES_4  = 2'h3;

  // internal oscillator frequency stand-in, and modulation half period
  localparam int  OSC_FREQ_KHZ   = 25000;
  localparam int  CLK_FREQ_KHZ   = 100000;
  localparam int  MOD_FREQ_KHZ   = 360;
  localparam logic [7:0] MOD_HALF_CYC = 8'((CLK_FREQ_KHZ / MOD_FREQ_KHZ) / 2);

  // bus transfer codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_DONE} conv_state_e;

  typedef struct packed {
    logic       scheme;
    logic       freq;
    logic [1:0] drive;
    logic [1:0] res;
    logic [1:0] range;
  } cmd2_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] count;
  } result_s;

endpackage
`default_nettype wire

/* File: lps_integrator.sv */
`timescale 1ns/1ps
`default_nettype none
// n-bit integration counter clocked from the oscillator tick
module lps_integrator (
  input  wire  logic                   clk,
  input  wire  logic                   arst_n,
  input  wire  logic                   start,
  input  wire  logic                   abort,
  input  wire  logic                   osc_tick,
  input  wire  logic [1:0]             res,
  input  wire  logic [15:0]            light_in,
  output var   logic                   busy,
  output var   lps_pkg::result_s       result
);

  logic [15:0] tick_cnt;
  logic [15:0] acc;
  logic [15:0] last_tick;

  always_comb begin
    unique case (res)
      lps_pkg::RES_16: last_tick = 16'hFFFF;
      lps_pkg::RES_12: last_tick = 16'h0FFF;
      lps_pkg::RES_8:  last_tick = 16'h00FF;
      default:         last_tick = 16'h000F;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy     <= 1'b0;
      tick_cnt <= 16'h0000;
      acc      <= 16'h0000;
      result   <= '0;
    end else begin
      result.valid <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        busy     <= 1'b1;
        tick_cnt <= 16'h0000;
        acc      <= 16'h0000;
      end else if (busy && osc_tick) begin
        // charge balance: one count per tick while input exceeds tick phase
        if (light_in > tick_cnt && acc != last_tick)
          acc <= acc + 16'h0001;
        if (tick_cnt == last_tick) begin
          busy         <= 1'b0;
          result.valid <= 1'b1;
          result.count <= acc & last_tick;
        end else begin
          tick_cnt <= tick_cnt + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: lps_ahb_host.sv */
`timescale 1ns/1ps
`default_nettype none
// single-word ahb-lite master standing in for the host that programs the sensor
module lps_ahb_host (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  output var  logic        hsel
);
  initial begin
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    hsel   = 1'b1;
  end

  // caller enters just after a rising edge; requests follow in any order the user needs
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rdat);
    haddr  <= {24'h0, a};
    htrans <= lps_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    // data lines show the inverted word in the address phase; a read data phase flips them back to the old word
    hwdata <= ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= w ? wd : ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rdat = hrdata;
  endtask
endmodule
`default_nettype wire

/* File: lps_mode_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module lps_mode_ctrl_tb;
  localparam logic [7:0] A_CMD1 = lps_pkg::CMD1_ADDR;
  localparam logic [7:0] A_CMD2 = lps_pkg::CMD2_ADDR;
  localparam logic [7:0] A_DATA = lps_pkg::DATA_ADDR;
  localparam logic [7:0] A_DIV  = lps_pkg::OSC_DIV_ADDR;
  logic        clk_sys    = 1'b0;
  logic        arst_n     = 1'b0;
  logic [15:0] light      = 16'h0000;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, led_cur, range_sel, sense;
  logic [2:0]  hsize;
  logic        hwrite, hsel, hready, hresp, led, conv;
  int          err_total  = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  always #5 clk_sys = ~clk_sys;

  lps_mode_ctrl lps_mode_ctrl_i (.CLK_SYS(clk_sys), .ARST_N(arst_n), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HSEL(hsel), .HREADY(hready), .LIGHT_IN(light),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .LED_DRIVE_EN(led), .LED_CURRENT_SEL(led_cur),
    .RANGE_SEL(range_sel), .SENSE_CHANNEL(sense), .CONV_ACTIVE(conv));

  lps_ahb_host lps_ahb_host_i (.clk(clk_sys), .hready(hready), .hrdata(hrdata), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel));

  task automatic end_of_test();
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    lps_ahb_host_i.xfer(a, 1'b1, d, unused);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] got;
    lps_ahb_host_i.xfer(a, 1'b0, 32'h0, got);
    chk(got, exp, what);
  endtask

  // bounded wait for one conversion to start and finish
  task automatic wait_conv(input int limit);
    int n;
    n = 0;
    while (conv !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    while (conv !== 1'b0 && n < limit) begin
      cyc(1);
      n++;
    end
    if (n >= limit) chk(32'h1, 32'h0, "conversion did not end");
  endtask

  // count saturates at the top of the selected n-bit range
  function automatic logic [31:0] sat(input logic [15:0] l, input logic [1:0] r);
    logic [31:0] top;
    top = (32'h1 << (16 - 4 * r)) - 32'h1;
    return ({16'h0000, l} > top) ? top : {16'h0000, l};
  endfunction

  task automatic t_reset();
    chk({30'h0, conv, led}, 32'h0, "idle after reset");
    rd_chk(A_DATA, 32'h0, "data at reset");
    rd_chk(A_CMD1, 32'h0, "mode at reset");
    rd_chk(lps_pkg::STATUS_ADDR, 32'h0, "status at reset");
    rd_chk(A_DIV, {16'h0000, lps_pkg::OSC_DIV_RESET}, "divider reset");
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0, "unmapped read");
    // zero would stall the oscillator, so it reads back as one
    wr(A_DIV, 32'h0);
    rd_chk(A_DIV, 32'h1, "divider floor");
    chk({31'h0, hresp}, 32'h0, "response okay");
  endtask

  task automatic t_one_shot(input logic [2:0] m, input logic [15:0] l, input logic [1:0] r);
    light <= l;
    wr(A_CMD2, {28'h0, r, 2'h0});
    wr(A_CMD1, {24'h0, m, 5'h00});
    cyc(3);
    chk({30'h0, conv, 1'b0}, 32'h2, "one-shot running");
    chk({30'h0, sense}, {30'h0, m[1:0]}, "one-shot channel");
    wait_conv(300);
    cyc(2);
    rd_chk(A_CMD1, 32'h0, "mode after one-shot");
    rd_chk(A_DATA, sat(l, r), "one-shot result");
    cyc(40);
    chk({31'h0, conv}, 32'h0, "stays powered down");
    rd_chk(A_DATA, sat(l, r), "result held");
  endtask

  task automatic t_cont();
    light <= 16'h0003;
    wr(A_CMD2, 32'h0000_000C);
    wr(A_CMD1, {24'h0, lps_pkg::MODE_IR_CONT, 5'h00});
    wait_conv(100);
    rd_chk(A_DATA, 32'h3, "first continuous result");
    wait_conv(100);
    light <= 16'h0009;
    wait_conv(100);
    rd_chk(A_DATA, 32'h9, "overwritten result");
  endtask

  task automatic t_prox();
    int hi;
    int lo;
    for (int k = 0; k < 4; k++) begin
      wr(A_CMD2, {26'h0, k[1:0], 2'h0, k[1:0]});
      cyc(2);
      chk({28'h0, led_cur, range_sel}, {28'h0, k[1:0], k[1:0]}, "drive and range");
    end
    for (int f = 0; f < 2; f++) begin
      hi = 0;
      lo = 0;
      // dc drive with 4-bit runs, then modulated drive over a long 8-bit run
      wr(A_CMD2, f == 0 ? 32'h0000_002C : 32'h0000_0058);
      wr(A_CMD1, {24'h0, lps_pkg::MODE_PROX_CONT, 5'h00});
      cyc(3);
      while (conv === 1'b1) begin
        if (led === 1'b1) hi++;
        else lo++;
        cyc(1);
      end
      chk({30'h0, hi > 0, f == 0 ? lo < 2 : lo > 0}, 32'h3, "led activity");
      wr(A_CMD1, 32'h0);
      cyc(3);
      repeat (30) begin
        chk({30'h0, conv, led}, 32'h0, "stopped by power-down");
        cyc(1);
      end
    end
  endtask

  task automatic t_modes();
    wr(A_CMD2, 32'h0000_0008);
    for (int m = 0; m < 8; m++) begin
      wr(A_CMD1, {24'h0, m[2:0], 5'h00});
      rd_chk(A_CMD1, {24'h0, m[2:0], 5'h00}, "mode stored");
      cyc(2);
      chk({30'h0, sense}, {30'h0, m[1:0]}, "mode channel");
      chk({31'h0, conv}, {31'h0, m != 0 && m != 4}, "mode converting");
    end
    wr(A_CMD1, 32'h0);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      $display("wrong value at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  initial begin
    cyc(20);
    arst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_one_shot(lps_pkg::MODE_AMB_ONCE, 16'h0005, lps_pkg::RES_4);
    t_one_shot(lps_pkg::MODE_IR_ONCE, 16'hFFFF, lps_pkg::RES_4);
    t_one_shot(lps_pkg::MODE_PROX_ONCE, 16'h00C8, lps_pkg::RES_8);
    t_one_shot(lps_pkg::MODE_AMB_ONCE, 16'h012C, lps_pkg::RES_8);
    t_cont();
    t_prox();
    t_modes();
    end_of_test();
  end
endmodule
`default_nettype wire
